// ---- pkg/scc_map.svh ----
// Register map, field positions and constants of the conditioner register bank.
// Assumes 16-bit register words and 5-bit register addresses.
`ifndef SCC_MAP_SVH
`define SCC_MAP_SVH
// ================================================================
// Register addresses
`define SCC_A_OSC        5'h05
`define SCC_A_BG         5'h06
`define SCC_A_CW1        5'h03
`define SCC_A_CW0        5'h04
`define SCC_A_SMO        5'h07
`define SCC_A_ADC        5'h08
`define SCC_A_OBJ        5'h09
`define SCC_A_AMB        5'h0A
`define SCC_A_IRD        5'h0B
`define SCC_A_TDD        5'h0C
`define SCC_A_IROS       5'h0D
`define SCC_A_TOS        5'h0E
`define SCC_A_MODE       5'h10
`define SCC_A_WP_LO      5'h18
// ================================================================
// Non-volatile word addresses and unlock codes
`define SCC_N_LOW_END    7'h07
`define SCC_N_HIGH_BEG   7'h78
`define SCC_TEST_CODE    7'h59
`define SCC_WP_CODE      7'h65
// ================================================================
// config_word_one bits
`define SCC_B_FATAL      15
`define SCC_B_DACSTOP    14
`define SCC_B_BATEN      13
`define SCC_B_ADCREF     12
`define SCC_B_POT        11
`define SCC_B_C1TGT      10
`define SCC_B_C1POL      9
`define SCC_B_BYP        8
`define SCC_B_RTGT       7
`define SCC_B_RPOL       6
`define SCC_B_WREN       5
`define SCC_B_TEST       4
// config_word_zero bits
`define SCC_B_OBJFN      15:14
`define SCC_B_AMBFN      13:12
`define SCC_B_SGNP       11
`define SCC_B_SGNN       10
`define SCC_B_NTC        9
`define SCC_B_INTV       8:5
// smoothing_config bits
`define SCC_B_GNDMSB     15
`define SCC_B_OSDIS      14
`define SCC_B_IROS       12
`define SCC_B_TOS        11
`define SCC_B_IRAVG      10:8
`define SCC_B_AMBAVG     7:5
// ================================================================
// Decode constants
`define SCC_INT_W0       8'h02
`define SCC_INT_W1       8'h11
`define SCC_INT_W2       8'h43
`define SCC_INT_W3       8'h86
`define SCC_AVG_BASE     4'h6
`define SCC_AVG_MAXCODE  3'h4
`define SCC_OS_BASE      4'h9
`define SCC_DATA_MAX     12'hFFF
`define SCC_DATA_MIN     12'h000
`define SCC_CW1_RST      16'h2000
`endif

// ---- pkg/scc_pkg.sv ----
// Types shared by the conditioner register bank modules.
// Assumes the map header is compiled alongside.
package scc_pkg;
  typedef enum logic {SCC_NORMAL, SCC_TEST} scc_mode_e;
  typedef struct packed {
    logic [1:0] obj_pin_fn;
    logic [1:0] amb_pin_fn;
    logic       cmp1_tgt_amb;
    logic       cmp1_noninv;
    logic       rly_tgt_amb;
    logic       rly_noninv;
    logic       rly_thr_pot;
    logic       temp_bypass;
    logic       adc_ref_int;
    logic       bat_reg_en;
    logic       dac_ref_stop;
    logic       therm_ntc;
    logic       curv_neg;
    logic       os_meas_en;
    logic [7:0] os_interval_s;
    logic [3:0] ir_os_log2;
    logic [3:0] t_os_log2;
    logic [3:0] ir_avg_log2;
    logic [3:0] amb_avg_log2;
    logic       ir_gnd_msb;
  } scc_cfg_s;
endpackage

// ---- rtl/scc_offset_comp.sv ----
// Offset compensation of one measurement chain.
// Assumes raw data and offset in the same two's complement scale.
`timescale 1ns/1ps
`default_nettype none
module scc_offset_comp #(
  parameter int W = 16
) (
  input  wire logic [W-1:0] raw_i,
  input  wire logic [W-1:0] offset_i,
  output logic      [W-1:0] comp_o
);
  assign comp_o = raw_i - offset_i;
endmodule
`default_nettype wire

// ---- rtl/scc_result_fmt.sv ----
// Packs a 12-bit temperature and the shared status bits into a result word.
// Assumes the caller supplies already range-forced data.
`timescale 1ns/1ps
`default_nettype none
module scc_result_fmt (
  input  wire logic [11:0] data_i,
  input  wire logic        ovf_i,
  input  wire logic        unf_i,
  input  wire logic        ftl_i,
  output logic      [15:0] word_o
);
  assign word_o = {data_i, ovf_i, unf_i, ftl_i, 1'b0};
endmodule
`default_nettype wire

// ---- rtl/scc_regs.sv ----
// Configuration, filter-control and result register bank of the conditioner.
// Assumes a serial front end that turns link frames into register strobes.
//
// Contract
// - Multi-bit non-volatile error at load sets the fatal flag.
// - Fatal flag clears only on leaving test mode with protection removed.
// - Battery regulator enabled at reset; only loaded data may disable it.
// - ADC reference select: 0 external, 1 internal on analog ground.
// - Relay threshold source: 0 stored threshold, 1 potentiometer pin.
// - Comparator one: target 0 object, 1 ambient; polarity 0 inverting.
// - Chain bypass: 0 amplifier to ADC, 1 thermistor pair direct.
// - Relay comparator: target 0 object, 1 ambient; polarity 0 inverting.
// - Write-enable and test indicators reset 0, ignore direct writes.
// - Object pin function codes 00 to 11 select four sources.
// - Ambient pin function codes 00 to 11 select four sources.
// - Thermistor type 0 PTC, 1 THERMISTOR_TYPE picks curvature sign bit.
// - Offset interval code selects sixteen intervals, 0 s to 220 s.
// - Trim and smoothing registers unreadable; writes need test mode.
// - Offset measurement control 0 enables, 1 disables both chains.
// - Offset averaging bit selects 512 or 1024 measurements per chain.
// - Depth codes 000 to 100 select 64 to 1024 points.
// - Conversion result readable always, writable in test mode only.
// - Result words hold data 15:4, flags 3:1, bit 0 zero.
// - Chain data stored after subtracting that chain's offset register.
// - Mode code 1011001 in bits 15:9 enters test mode.
// - Code 1100101 in bits 6:0 of protect register enables writes.
`timescale 1ns/1ps
`default_nettype none
`include "scc_map.svh"
module scc_regs
  import scc_pkg::*;
(
  // Clock and power-on reset
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  // Register access strobes from the serial front end
  input  wire logic [4:0]  REG_ADDR_I,
  input  wire logic        REG_WR_I,
  input  wire logic [15:0] REG_WDATA_I,
  input  wire logic        REG_RD_I,
  output logic      [15:0] REG_RDATA_O,
  output logic             REG_RVALID_O,
  // Non-volatile load after power-on and write permission
  input  wire logic        NVM_LD_I,
  input  wire logic [2:0]  NVM_LD_ADDR_I,
  input  wire logic [15:0] NVM_LD_DATA_I,
  input  wire logic        NVM_MULTI_ERR_I,
  input  wire logic        NVM_WR_REQ_I,
  input  wire logic [6:0]  NVM_WR_ADDR_I,
  output logic             NVM_WR_GO_O,
  // Measurement and linearisation results
  input  wire logic        ADC_DONE_I,
  input  wire logic [15:0] ADC_DATA_I,
  input  wire logic        IR_MEAS_I,
  input  wire logic [15:0] IR_RAW_I,
  input  wire logic        TEMP_MEAS_I,
  input  wire logic [15:0] TEMP_RAW_I,
  input  wire logic        OBJ_LIN_I,
  input  wire logic [11:0] OBJ_TEMP_I,
  input  wire logic        AMB_LIN_I,
  input  wire logic [11:0] AMB_TEMP_I,
  input  wire logic        AMB_OVER_I,
  input  wire logic        AMB_UNDER_I,
  // Configuration and mode outputs
  output scc_cfg_s         CFG_O,
  output logic [15:0]      OSC_TRIM_O,
  output logic [15:0]      BG_TRIM_O,
  output logic             TEST_MODE_O,
  output logic             NVM_WREN_O
);
  // ================================================================
  // State
  logic [15:0] cw1_reg, cw1_next, cw0_reg, cw0_next, smo_reg, smo_next;
  logic [15:0] osc_reg, osc_next, bg_reg, bg_next, adc_reg, adc_next;
  logic [11:0] obj_reg, obj_next, amb_reg, amb_next;
  logic        ovf_reg, ovf_next, unf_reg, unf_next;
  logic [15:0] ird_reg, ird_next, tdd_reg, tdd_next;
  logic [15:0] iros_reg, iros_next, tos_reg, tos_next;
  scc_mode_e   mode_reg, mode_next;
  logic        wp_off_reg, wp_off_next, armed_reg, armed_next;
  logic [15:0] rdata_reg, rdata_next;
  logic        rvalid_reg, rvalid_next, go_reg, go_next;
  scc_cfg_s    cfg_reg, cfg_next;
  logic [15:0] ir_comp, t_comp, obj_word, amb_word, cw1_view;
  logic        test_on, wr_test;

  assign test_on = (mode_reg == SCC_TEST);
  assign wr_test = REG_WR_I && test_on;

  // ================================================================
  // Chain compensation and result packing
  scc_offset_comp #(.W(16)) u_ir_comp (
    .raw_i    (IR_RAW_I),
    .offset_i (iros_reg),
    .comp_o   (ir_comp)
  );
  scc_offset_comp #(.W(16)) u_t_comp (
    .raw_i    (TEMP_RAW_I),
    .offset_i (tos_reg),
    .comp_o   (t_comp)
  );
  scc_result_fmt u_obj_fmt (
    .data_i (obj_reg),
    .ovf_i  (ovf_reg),
    .unf_i  (unf_reg),
    .ftl_i  (cw1_reg[`SCC_B_FATAL]),
    .word_o (obj_word)
  );
  scc_result_fmt u_amb_fmt (
    .data_i (amb_reg),
    .ovf_i  (ovf_reg),
    .unf_i  (unf_reg),
    .ftl_i  (cw1_reg[`SCC_B_FATAL]),
    .word_o (amb_word)
  );

  // Indicator bits are never stored; they mirror mode and protection.
  always_comb begin
    cw1_view = cw1_reg;
    cw1_view[`SCC_B_WREN] = wp_off_reg;
    cw1_view[`SCC_B_TEST] = test_on;
  end

  // ================================================================
  // Mode, protection and configuration words
  always_comb begin
    mode_next   = mode_reg;
    wp_off_next = wp_off_reg;
    armed_next  = armed_reg;
    cw1_next    = cw1_reg;
    cw0_next    = cw0_reg;
    smo_next    = smo_reg;
    osc_next    = osc_reg;
    bg_next     = bg_reg;
    if (REG_WR_I && REG_ADDR_I == `SCC_A_MODE) begin
      mode_next = (REG_WDATA_I[15:9] == `SCC_TEST_CODE) ? SCC_TEST : SCC_NORMAL;
    end
    if (REG_WR_I && REG_ADDR_I >= `SCC_A_WP_LO) begin
      wp_off_next = (REG_WDATA_I[6:0] == `SCC_WP_CODE);
    end
    if (test_on && wp_off_reg) begin
      armed_next = 1'b1;
    end else if (!test_on) begin
      armed_next = 1'b0;
    end
    if (wr_test) begin
      case (REG_ADDR_I)
        `SCC_A_CW1: begin
          // Fatal, regulator and indicator bits are not host-writable.
          cw1_next[`SCC_B_DACSTOP:`SCC_B_RPOL] = {cw1_reg[`SCC_B_DACSTOP],
            cw1_reg[`SCC_B_BATEN], REG_WDATA_I[`SCC_B_ADCREF:`SCC_B_RPOL]};
          cw1_next[`SCC_B_DACSTOP] = REG_WDATA_I[`SCC_B_DACSTOP];
        end
        `SCC_A_CW0: cw0_next = REG_WDATA_I;
        `SCC_A_SMO: smo_next = REG_WDATA_I;
        `SCC_A_OSC: osc_next = REG_WDATA_I;
        `SCC_A_BG:  bg_next  = REG_WDATA_I;
        default: ;
      endcase
    end
    if (NVM_LD_I) begin
      case ({2'b00, NVM_LD_ADDR_I})
        `SCC_A_CW1: cw1_next[`SCC_B_DACSTOP:`SCC_B_TEST] = NVM_LD_DATA_I[15:5];
        `SCC_A_CW0: cw0_next = NVM_LD_DATA_I;
        `SCC_A_SMO: smo_next = NVM_LD_DATA_I;
        `SCC_A_OSC: osc_next = NVM_LD_DATA_I;
        `SCC_A_BG:  bg_next  = NVM_LD_DATA_I;
        default: ;
      endcase
    end
    cw1_next[`SCC_B_WREN] = 1'b0;
    cw1_next[`SCC_B_TEST] = 1'b0;
    cw1_next[3:0] = 4'h0;
    if (armed_reg && mode_next == SCC_NORMAL) begin
      cw1_next[`SCC_B_FATAL] = 1'b0;
    end
    if (NVM_LD_I && NVM_MULTI_ERR_I) begin
      cw1_next[`SCC_B_FATAL] = 1'b1;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      mode_reg   <= SCC_NORMAL;
      wp_off_reg <= 1'b0;
      armed_reg  <= 1'b0;
      cw1_reg    <= `SCC_CW1_RST;
      cw0_reg    <= 16'h0000;
      smo_reg    <= 16'h0000;
      osc_reg    <= 16'h0000;
      bg_reg     <= 16'h0000;
    end else begin
      mode_reg   <= mode_next;
      wp_off_reg <= wp_off_next;
      armed_reg  <= armed_next;
      cw1_reg    <= cw1_next;
      cw0_reg    <= cw0_next;
      smo_reg    <= smo_next;
      osc_reg    <= osc_next;
      bg_reg     <= bg_next;
    end
  end

  // ================================================================
  // Data registers: hardware updates win over test-mode writes
  always_comb begin
    adc_next  = adc_reg;
    obj_next  = obj_reg;
    amb_next  = amb_reg;
    ovf_next  = ovf_reg;
    unf_next  = unf_reg;
    ird_next  = ird_reg;
    tdd_next  = tdd_reg;
    iros_next = iros_reg;
    tos_next  = tos_reg;
    if (wr_test) begin
      case (REG_ADDR_I)
        `SCC_A_ADC:  adc_next  = REG_WDATA_I;
        `SCC_A_OBJ:  obj_next  = REG_WDATA_I[15:4];
        `SCC_A_AMB:  amb_next  = REG_WDATA_I[15:4];
        `SCC_A_IRD:  ird_next  = REG_WDATA_I;
        `SCC_A_TDD:  tdd_next  = REG_WDATA_I;
        `SCC_A_IROS: iros_next = REG_WDATA_I;
        `SCC_A_TOS:  tos_next  = REG_WDATA_I;
        default: ;
      endcase
    end
    if (ADC_DONE_I) begin
      adc_next = ADC_DATA_I;
    end
    if (IR_MEAS_I) begin
      ird_next = ir_comp;
    end
    if (TEMP_MEAS_I) begin
      tdd_next = t_comp;
    end
    if (OBJ_LIN_I) begin
      obj_next = OBJ_TEMP_I;
    end
    if (AMB_LIN_I) begin
      ovf_next = AMB_OVER_I;
      unf_next = AMB_UNDER_I && !AMB_OVER_I;
      if (AMB_OVER_I) begin
        amb_next = `SCC_DATA_MAX;
      end else if (AMB_UNDER_I) begin
        amb_next = `SCC_DATA_MIN;
      end else begin
        amb_next = AMB_TEMP_I;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      adc_reg  <= 16'h0000;
      obj_reg  <= 12'h000;
      amb_reg  <= 12'h000;
      ovf_reg  <= 1'b0;
      unf_reg  <= 1'b0;
      ird_reg  <= 16'h0000;
      tdd_reg  <= 16'h0000;
      iros_reg <= 16'h0000;
      tos_reg  <= 16'h0000;
    end else begin
      adc_reg  <= adc_next;
      obj_reg  <= obj_next;
      amb_reg  <= amb_next;
      ovf_reg  <= ovf_next;
      unf_reg  <= unf_next;
      ird_reg  <= ird_next;
      tdd_reg  <= tdd_next;
      iros_reg <= iros_next;
      tos_reg  <= tos_next;
    end
  end

  // ================================================================
  // Read port, write permission and decoded configuration
  always_comb begin
    rvalid_next = REG_RD_I;
    rdata_next  = rdata_reg;
    if (REG_RD_I) begin
      case (REG_ADDR_I)
        `SCC_A_CW1:  rdata_next = cw1_view;
        `SCC_A_CW0:  rdata_next = cw0_reg;
        `SCC_A_ADC:  rdata_next = adc_reg;
        `SCC_A_OBJ:  rdata_next = obj_word;
        `SCC_A_AMB:  rdata_next = amb_word;
        `SCC_A_IRD:  rdata_next = ird_reg;
        `SCC_A_TDD:  rdata_next = tdd_reg;
        `SCC_A_IROS: rdata_next = iros_reg;
        `SCC_A_TOS:  rdata_next = tos_reg;
        default:     rdata_next = 16'h0000;
      endcase
    end
    go_next = NVM_WR_REQ_I && wp_off_reg &&
              (test_on || (NVM_WR_ADDR_I > `SCC_N_LOW_END &&
                           NVM_WR_ADDR_I < `SCC_N_HIGH_BEG));
    cfg_next.obj_pin_fn   = cw0_reg[`SCC_B_OBJFN];
    cfg_next.amb_pin_fn   = cw0_reg[`SCC_B_AMBFN];
    cfg_next.cmp1_tgt_amb = cw1_reg[`SCC_B_C1TGT];
    cfg_next.cmp1_noninv  = cw1_reg[`SCC_B_C1POL];
    cfg_next.rly_tgt_amb  = cw1_reg[`SCC_B_RTGT];
    cfg_next.rly_noninv   = cw1_reg[`SCC_B_RPOL];
    cfg_next.rly_thr_pot  = cw1_reg[`SCC_B_POT];
    cfg_next.temp_bypass  = cw1_reg[`SCC_B_BYP];
    cfg_next.adc_ref_int  = cw1_reg[`SCC_B_ADCREF];
    cfg_next.bat_reg_en   = cw1_reg[`SCC_B_BATEN];
    cfg_next.dac_ref_stop = cw1_reg[`SCC_B_DACSTOP];
    cfg_next.therm_ntc    = cw0_reg[`SCC_B_NTC];
    cfg_next.curv_neg     = cw0_reg[`SCC_B_NTC] ? cw0_reg[`SCC_B_SGNN]
                                                : cw0_reg[`SCC_B_SGNP];
    cfg_next.os_meas_en   = !smo_reg[`SCC_B_OSDIS];
    cfg_next.os_interval_s = (cw0_reg[5] ? `SCC_INT_W0 : 8'h00) +
                             (cw0_reg[6] ? `SCC_INT_W1 : 8'h00) +
                             (cw0_reg[7] ? `SCC_INT_W2 : 8'h00) +
                             (cw0_reg[8] ? `SCC_INT_W3 : 8'h00);
    cfg_next.ir_os_log2   = `SCC_OS_BASE + {3'h0, smo_reg[`SCC_B_IROS]};
    cfg_next.t_os_log2    = `SCC_OS_BASE + {3'h0, smo_reg[`SCC_B_TOS]};
    cfg_next.ir_avg_log2  = `SCC_AVG_BASE + ((smo_reg[`SCC_B_IRAVG] > `SCC_AVG_MAXCODE) ?
                            {1'b0, `SCC_AVG_MAXCODE} : {1'b0, smo_reg[`SCC_B_IRAVG]});
    cfg_next.amb_avg_log2 = `SCC_AVG_BASE + ((smo_reg[`SCC_B_AMBAVG] > `SCC_AVG_MAXCODE) ?
                            {1'b0, `SCC_AVG_MAXCODE} : {1'b0, smo_reg[`SCC_B_AMBAVG]});
    cfg_next.ir_gnd_msb   = smo_reg[`SCC_B_GNDMSB];
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      rdata_reg   <= 16'h0000;
      rvalid_reg  <= 1'b0;
      go_reg      <= 1'b0;
      cfg_reg     <= '0;
      TEST_MODE_O <= 1'b0;
      NVM_WREN_O  <= 1'b0;
      OSC_TRIM_O  <= 16'h0000;
      BG_TRIM_O   <= 16'h0000;
    end else begin
      rdata_reg   <= rdata_next;
      rvalid_reg  <= rvalid_next;
      go_reg      <= go_next;
      cfg_reg     <= cfg_next;
      TEST_MODE_O <= test_on;
      NVM_WREN_O  <= wp_off_reg;
      OSC_TRIM_O  <= osc_reg;
      BG_TRIM_O   <= bg_reg;
    end
  end

  assign REG_RDATA_O  = rdata_reg;
  assign REG_RVALID_O = rvalid_reg;
  assign NVM_WR_GO_O  = go_reg;
  assign CFG_O        = cfg_reg;

  // ================================================================
  // Assertions
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  fatal_set_a: assert property (NVM_LD_I && NVM_MULTI_ERR_I |=> cw1_reg[`SCC_B_FATAL])
    else $error("fatal flag not set on multi-bit error");
  fatal_hold_a: assert property (cw1_reg[`SCC_B_FATAL] && !armed_reg |=> cw1_reg[`SCC_B_FATAL])
    else $error("fatal flag cleared without unlock sequence");
  bat_write_a: assert property (wr_test && !NVM_LD_I |=> $stable(cw1_reg[`SCC_B_BATEN]))
    else $error("regulator enable changed by host write");
  test_enter_a: assert property (REG_WR_I && REG_ADDR_I == `SCC_A_MODE
    && REG_WDATA_I[15:9] == `SCC_TEST_CODE |=> ##1 TEST_MODE_O)
    else $error("test mode not entered");
  wp_code_a: assert property (REG_WR_I && REG_ADDR_I >= `SCC_A_WP_LO
    && REG_WDATA_I[6:0] != `SCC_WP_CODE |=> ##1 !NVM_WREN_O)
    else $error("protection not restored");
  trim_lock_a: assert property (!test_on |=> $stable(osc_reg) || $past(NVM_LD_I))
    else $error("trim written outside test mode");
  trim_read_a: assert property (REG_RD_I && REG_ADDR_I == `SCC_A_SMO |=> REG_RDATA_O == 16'h0000)
    else $error("smoothing register readable");
  amb_over_a: assert property (AMB_LIN_I && AMB_OVER_I |=> ##1 REG_RD_I && REG_ADDR_I == `SCC_A_AMB
    |=> REG_RDATA_O[15:3] == {`SCC_DATA_MAX, 1'b1})
    else $error("over-range not forced");
  ir_comp_a: assert property (IR_MEAS_I |=> ird_reg == $past(IR_RAW_I) - $past(iros_reg))
    else $error("chain data not compensated");
  go_a: assert property (NVM_WR_REQ_I && !wp_off_reg |=> !NVM_WR_GO_O)
    else $error("write granted while protected");
  res_bit_a: assert property (REG_RVALID_O && $past(REG_ADDR_I) == `SCC_A_OBJ |-> !REG_RDATA_O[0])
    else $error("result bit 0 not zero");

  enter_test_c: cover property (!test_on ##1 test_on);
  fatal_clear_c: cover property (cw1_reg[`SCC_B_FATAL] ##1 !cw1_reg[`SCC_B_FATAL]);
  go_c: cover property (NVM_WR_GO_O);
endmodule
`default_nettype wire

// ---- test/scc_host_model.sv ----
// Host model that issues register strobes as the serial front end would.
// Assumes the map header is on the include path and one shared clock.
`timescale 1ns/1ps
`default_nettype none
`include "scc_map.svh"
module scc_host_model
  import scc_pkg::*;
(
  // Clock
  input  wire logic        clk_i,
  // Register strobes
  output logic      [4:0]  addr_o,
  output logic             wr_o,
  output logic      [15:0] wdata_o,
  output logic             rd_o,
  input  wire logic [15:0] rdata_i
);
  // ================================================================
  // Bus cycles
  initial begin
    addr_o = 5'h1F;
    wr_o = 1'b0;
    wdata_o = 16'h0000;
    rd_o = 1'b0;
  end
  // Released lines show the inverse of the last value.
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    wdata_o = (a == `SCC_A_SMO) ? (d & 16'hDFFF) : d;
    wr_o = 1'b1;
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~wdata_o;
  endtask
  task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    rd_o = 1'b1;
    @(posedge clk_i);
    #1;
    rd_o = 1'b0;
    d = rdata_i;
    addr_o = ~a;
  endtask
endmodule
`default_nettype wire

// ---- test/scc_regs_tb_top.sv ----
// Self-checking bench of the conditioner register bank.
// Assumes the host model drives the register strobes on a 25 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "scc_map.svh"
module scc_regs_tb_top
  import scc_pkg::*;
;
  // ================================================================
  // Signals and instances
  logic CLK_I = 1'b0, RST_I = 1'b1;
  logic [4:0] addr;
  logic wr, rd, rvalid, go, tm, wren;
  logic [15:0] wdata, rdata, osc, bg, v;
  logic nvm_ld = 0, nvm_err = 0, nvm_req = 0, adc_done = 0, ir_m = 0, t_m = 0;
  logic obj_l = 0, amb_l = 0, amb_o = 0, amb_u = 0;
  logic [2:0] nvm_la = 3'h3;
  logic [6:0] nvm_wa = 7'h00;
  logic [15:0] nvm_d = 16'h0000, adc_d = 16'h0000, ir_r = 16'h0000, t_r = 16'h0000;
  logic [11:0] obj_t = 12'h000, amb_t = 12'h000;
  scc_cfg_s cfg;
  int n_fail = 0, comparisons = 0;
  always #20 CLK_I = ~CLK_I;
  scc_host_model host (.clk_i(CLK_I), .addr_o(addr), .wr_o(wr), .wdata_o(wdata),
    .rd_o(rd), .rdata_i(rdata));
  scc_regs uut (.CLK_I(CLK_I), .RST_I(RST_I), .REG_ADDR_I(addr), .REG_WR_I(wr),
    .REG_WDATA_I(wdata), .REG_RD_I(rd), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
    .NVM_LD_I(nvm_ld), .NVM_LD_ADDR_I(nvm_la), .NVM_LD_DATA_I(nvm_d),
    .NVM_MULTI_ERR_I(nvm_err), .NVM_WR_REQ_I(nvm_req), .NVM_WR_ADDR_I(nvm_wa),
    .NVM_WR_GO_O(go), .ADC_DONE_I(adc_done), .ADC_DATA_I(adc_d), .IR_MEAS_I(ir_m),
    .IR_RAW_I(ir_r), .TEMP_MEAS_I(t_m), .TEMP_RAW_I(t_r), .OBJ_LIN_I(obj_l),
    .OBJ_TEMP_I(obj_t), .AMB_LIN_I(amb_l), .AMB_TEMP_I(amb_t), .AMB_OVER_I(amb_o),
    .AMB_UNDER_I(amb_u), .CFG_O(cfg), .OSC_TRIM_O(osc), .BG_TRIM_O(bg),
    .TEST_MODE_O(tm), .NVM_WREN_O(wren));
  // ================================================================
  // Shared tasks
  task automatic tick;
    @(posedge CLK_I);
    #1;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [4:0] a, input logic [15:0] exp);
    host.rd_reg(a, v);
    check(v, exp);
    check(rvalid, 1'b1);
  endtask
  task automatic wset(input logic [4:0] a, input logic [15:0] d);
    host.wr_reg(a, d);
    tick;
    tick;
  endtask
  task automatic nvm_try(input logic [6:0] a, input logic e);
    nvm_wa = a;
    nvm_req = 1'b1;
    tick;
    nvm_req = 1'b0;
    check(go, e);
  endtask
  task automatic stop_test;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ================================================================
  // Scenarios
  task automatic t_mode;
    check({tm, wren, cfg.bat_reg_en}, 16'h1);
    host.wr_reg(`SCC_A_MODE, 16'hB200);
    tick;
    check(tm, 1'b1);
    host.wr_reg(`SCC_A_WP_LO, 16'h0065);
    tick;
    check(wren, 1'b1);
    host.wr_reg(`SCC_A_CW1, 16'h0000);
    rchk(`SCC_A_CW1, 16'h2030);
    nvm_try(7'h00, 1'b1);
    $display("test mode done");
  endtask
  task automatic t_cfg;
    logic [15:0] w1 [2] = '{16'h1540, 16'h0A80};
    logic [3:0] cd [4] = '{4'h0, 4'h1, 4'h2, 4'hF};
    logic [7:0] sec [4] = '{8'h00, 8'h02, 8'h11, 8'hDC};
    for (int k = 0; k < 2; k++) begin
      wset(`SCC_A_CW1, w1[k]);
      check({cfg.adc_ref_int, cfg.rly_thr_pot}, {w1[k][12], w1[k][11]});
      check({cfg.cmp1_tgt_amb, cfg.cmp1_noninv}, w1[k][10:9]);
      check(cfg.temp_bypass, w1[k][8]);
      check({cfg.rly_tgt_amb, cfg.rly_noninv, cfg.bat_reg_en}, {w1[k][7:6], 1'b1});
    end
    for (int k = 0; k < 4; k++) begin
      wset(`SCC_A_CW0, {k[1:0], k[1:0], k[1], ~k[1], k[0], cd[k], 5'h00});
      check(cfg.obj_pin_fn, k[1:0]);
      check(cfg.amb_pin_fn, k[1:0]);
      check(cfg.curv_neg, k[0] ? !k[1] : k[1]);
      check(cfg.os_interval_s, sec[k]);
    end
    $display("test cfg done");
  endtask
  task automatic t_smooth;
    logic [15:0] ws [2] = '{16'h74E0, 16'h0860};
    logic [16:0] e [2] = '{{1'b0, 16'hA9AA}, {1'b1, 16'h9A69}};
    for (int k = 0; k < 2; k++) begin
      wset(`SCC_A_SMO, ws[k]);
      check(cfg.os_meas_en, e[k][16]);
      check({cfg.ir_os_log2, cfg.t_os_log2}, e[k][15:8]);
      check({cfg.ir_avg_log2, cfg.amb_avg_log2}, e[k][7:0]);
    end
    wset(`SCC_A_OSC, 16'h5A5A);
    wset(`SCC_A_BG, 16'hC3C3);
    check(osc, 16'h5A5A);
    check(bg, 16'hC3C3);
    rchk(`SCC_A_SMO, 16'h0000);
    rchk(`SCC_A_OSC, 16'h0000);
    $display("test smooth done");
  endtask
  task automatic t_data;
    host.wr_reg(`SCC_A_IROS, 16'h0010);
    host.wr_reg(`SCC_A_TOS, 16'h0003);
    ir_r = 16'h0100;
    t_r = 16'h0001;
    adc_d = 16'hA5C3;
    {ir_m, t_m, adc_done} = 3'h7;
    tick;
    {ir_m, t_m, adc_done} = 3'h0;
    rchk(`SCC_A_IRD, 16'h00F0);
    rchk(`SCC_A_TDD, 16'hFFFE);
    rchk(`SCC_A_ADC, 16'hA5C3);
    host.wr_reg(`SCC_A_MODE, 16'h0000);
    host.wr_reg(`SCC_A_ADC, 16'h0000);
    rchk(`SCC_A_ADC, 16'hA5C3);
    wset(`SCC_A_OSC, 16'h1234);
    check(osc, 16'h5A5A);
    nvm_try(7'h00, 1'b0);
    $display("test data done");
  endtask
  task automatic t_result;
    amb_t = 12'h555;
    obj_t = 12'h123;
    for (int k = 0; k < 2; k++) begin
      {amb_o, amb_u} = k ? 2'b01 : 2'b10;
      amb_l = 1'b1;
      tick;
      amb_l = 1'b0;
      rchk(`SCC_A_AMB, k ? 16'h0004 : 16'hFFF8);
    end
    obj_l = 1'b1;
    tick;
    obj_l = 1'b0;
    rchk(`SCC_A_OBJ, 16'h1234);
    $display("test result done");
  endtask
  task automatic t_fatal;
    nvm_err = 1'b1;
    nvm_ld = 1'b1;
    tick;
    {nvm_ld, nvm_err} = 2'b00;
    tick;
    check(cfg.bat_reg_en, 1'b0);
    rchk(`SCC_A_OBJ, 16'h1236);
    rchk(`SCC_A_CW1, 16'h8020);
    host.wr_reg(`SCC_A_MODE, 16'hB200);
    host.wr_reg(`SCC_A_MODE, 16'h0000);
    rchk(`SCC_A_CW1, 16'h0020);
    $display("test fatal done");
  endtask
  // ================================================================
  // Main sequence and watchdog
  initial begin
    repeat (2) @(posedge CLK_I);
    #1;
    RST_I = 1'b0;
    tick;
    t_mode;
    t_cfg;
    t_smooth;
    t_data;
    t_result;
    t_fatal;
    stop_test;
  end
  initial begin
    #100000;
    n_fail++;
    stop_test;
  end
endmodule
`default_nettype wire
